// file: rspc_pkg.sv
/*
  Constants, register map and types for the radio state power
  configuration block. Assumes a single 25 MHz crystal-derived clock.
*/
package rspc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_CFG_B = 6'h17;
  localparam logic [5:0] ADDR_CFG_A = 6'h18;

  localparam int POLICY_LSB = 4;
  localparam int WAIT_LSB   = 2;
  localparam int PIN_EN_BIT = 1;
  localparam int KEEP_BIT   = 0;

  localparam logic [1:0] POLICY_RST  = 2'h0;
  localparam logic [1:0] WAIT_RST    = 2'h1;
  localparam logic [7:0] CFG_B_RST   = 8'h00;

  // ---------------------------------------------------------------
  // calibration policies and expiration counts
  // ---------------------------------------------------------------
  localparam logic [1:0] CAL_NEVER    = 2'h0;
  localparam logic [1:0] CAL_ON_EXIT  = 2'h1;
  localparam logic [1:0] CAL_ON_IDLE  = 2'h2;
  localparam logic [1:0] CAL_EVERY_4  = 2'h3;

  localparam logic [8:0] EXPIRE_0 = 9'h001;
  localparam logic [8:0] EXPIRE_1 = 9'h010;
  localparam logic [8:0] EXPIRE_2 = 9'h040;
  localparam logic [8:0] EXPIRE_3 = 9'h100;

  localparam int RIPPLE_BITS = 6;

  typedef enum logic [1:0] {
    PU_OFF    = 2'b00,
    PU_COUNT  = 2'b01,
    PU_READY  = 2'b11
  } rspc_pu_t;

  function automatic logic [8:0] expire_count(input logic [1:0] sel);
    case (sel)
      2'h0:    expire_count = EXPIRE_0;
      2'h1:    expire_count = EXPIRE_1;
      2'h2:    expire_count = EXPIRE_2;
      default: expire_count = EXPIRE_3;
    endcase
  endfunction

endpackage

// file: rspc_ripple_wait.sv
/*
  Power-on wait: a free ripple counter whose expirations are counted
  up to a target. Assumes i_run is a clean same-clock level.
*/
`timescale 1ns/10ps
module rspc_ripple_wait
  import rspc_pkg::*;
#(
  parameter int RIPPLE_W = RIPPLE_BITS
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_run,
  input  wire logic [8:0] i_target,
  output logic            o_done
);

  logic [RIPPLE_W-1:0] ripple_q;
  logic [8:0]          exp_q;
  logic                expire;

  assign expire = &ripple_q;

  // ---------------------------------------------------------------
  // ripple counter and expiration count
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ripple_q <= '0;
    end else if (!i_run) begin
      ripple_q <= '0;
    end else begin
      ripple_q <= ripple_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      exp_q <= 9'h000;
    end else if (!i_run) begin
      exp_q <= 9'h000;
    end else if (expire && !o_done) begin
      exp_q <= exp_q + 9'h001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_done <= 1'b0;
    end else if (!i_run) begin
      o_done <= 1'b0;
    end else if (expire && (exp_q + 9'h001 == i_target)) begin
      o_done <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_done_on_target: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_done) |-> $past(i_run) && exp_q == i_target)
    else $error("wait ended before target expirations");
  a_done_drops: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_run |=> !o_done)
    else $error("wait done stayed set without run");

endmodule

// file: rspc_top.sv
/*
  Radio state power configuration: calibration policy, power-on wait
  and chip ready, crystal keep-alive in sleep, pin control gating.
  Assumes radio state events and host writes come on I_CLK; the
  crystal stable flag and control pins are asynchronous.
*/
`timescale 1ns/10ps
module rspc_top
  import rspc_pkg::*;
#(
  parameter int RIPPLE_W = RIPPLE_BITS
) (
  input  wire logic       I_CLK,
  input  wire logic       I_RST_N,
  input  wire logic       i_WR_EN,
  input  wire logic [5:0] i_ADDR,
  input  wire logic [7:0] i_WDATA,
  output logic      [7:0] o_RDATA,
  input  wire logic       i_MANUAL_CAL,
  input  wire logic       i_LEAVE_IDLE,
  input  wire logic       i_BACK_TO_IDLE,
  input  wire logic       i_SLEEP,
  input  wire logic       i_XTAL_STABLE,
  input  wire logic [2:0] i_PIN_CTRL,
  output logic            o_CAL_START,
  output logic            o_CHIP_READY_N,
  output logic            o_XTAL_EN,
  output logic      [2:0] o_PIN_CMD
);

  // ---------------------------------------------------------------
  // reset release and input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  logic       xtal_s1_q;
  logic       xtal_s2_q;
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      xtal_s1_q <= 1'b0;
      xtal_s2_q <= 1'b0;
      pin_s1_q  <= 3'h0;
      pin_s2_q  <= 3'h0;
    end else begin
      xtal_s1_q <= i_XTAL_STABLE;
      xtal_s2_q <= xtal_s1_q;
      pin_s1_q  <= i_PIN_CTRL;
      pin_s2_q  <= pin_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [1:0] synth_cal_policy_q;
  logic [1:0] power_on_wait_select_q;
  logic       pin_ctrl_en_q;
  logic       keep_crystal_running_q;
  logic [7:0] cfg_b_q;
  logic [7:0] cfg_a_rd;

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      synth_cal_policy_q     <= POLICY_RST;
      power_on_wait_select_q <= WAIT_RST;
      pin_ctrl_en_q          <= 1'b0;
      keep_crystal_running_q <= 1'b0;
    end else if (i_WR_EN && i_ADDR == ADDR_CFG_A) begin
      synth_cal_policy_q     <= i_WDATA[POLICY_LSB +: 2];
      power_on_wait_select_q <= i_WDATA[WAIT_LSB +: 2];
      pin_ctrl_en_q          <= i_WDATA[PIN_EN_BIT];
      keep_crystal_running_q <= i_WDATA[KEEP_BIT];
    end
  end

  // layout of this neighbour is not defined here; it is plain storage
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_b_q <= CFG_B_RST;
    end else if (i_WR_EN && i_ADDR == ADDR_CFG_B) begin
      cfg_b_q <= i_WDATA;
    end
  end

  // upper bits have no storage, so writes to them vanish
  assign cfg_a_rd = {2'b00, synth_cal_policy_q, power_on_wait_select_q,
                     pin_ctrl_en_q, keep_crystal_running_q};

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      o_RDATA <= 8'h00;
    end else begin
      case (i_ADDR)
        ADDR_CFG_A: o_RDATA <= cfg_a_rd;
        ADDR_CFG_B: o_RDATA <= cfg_b_q;
        default:    o_RDATA <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // synthesizer calibration
  // ---------------------------------------------------------------
  logic [1:0] idle_count_q;
  logic       cal_d;

  // counts returns to idle under policy three only; wraps every fourth
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      idle_count_q <= 2'h0;
    end else if (synth_cal_policy_q != CAL_EVERY_4) begin
      idle_count_q <= 2'h0;
    end else if (i_BACK_TO_IDLE) begin
      idle_count_q <= idle_count_q + 2'h1;
    end
  end

  always_comb begin
    cal_d = i_MANUAL_CAL;
    case (synth_cal_policy_q)
      CAL_NEVER:   cal_d = i_MANUAL_CAL;
      CAL_ON_EXIT: cal_d = cal_d | i_LEAVE_IDLE;
      CAL_ON_IDLE: cal_d = cal_d | i_BACK_TO_IDLE;
      CAL_EVERY_4: cal_d = cal_d | (i_BACK_TO_IDLE &&
                                    idle_count_q == 2'h3);
      default:     cal_d = i_MANUAL_CAL;
    endcase
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      o_CAL_START <= 1'b0;
    end else begin
      o_CAL_START <= cal_d;
    end
  end

  // ---------------------------------------------------------------
  // power-on wait and chip ready
  // ---------------------------------------------------------------
  rspc_pu_t pu_q;
  logic     wait_done;
  logic     wait_run;

  assign wait_run = (pu_q != PU_OFF) && xtal_s2_q;

  // the ripple count runs on the crystal clock, so the delay scales
  // with crystal frequency; a short setting only suits a cold start
  rspc_ripple_wait #(
    .RIPPLE_W (RIPPLE_W)
  ) u_wait (
    .i_clk    (I_CLK),
    .i_rst_n  (rst_n),
    .i_run    (wait_run),
    .i_target (expire_count(power_on_wait_select_q)),
    .o_done   (wait_done)
  );

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pu_q <= PU_OFF;
    end else begin
      case (pu_q)
        PU_OFF:   if (xtal_s2_q) pu_q <= PU_COUNT;
        PU_COUNT: begin
          if (!xtal_s2_q) begin
            pu_q <= PU_OFF;
          end else if (wait_done) begin
            pu_q <= PU_READY;
          end
        end
        PU_READY: if (!xtal_s2_q) pu_q <= PU_OFF;
        default:  pu_q <= PU_OFF;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      o_CHIP_READY_N <= 1'b1;
    end else begin
      o_CHIP_READY_N <= !(pu_q == PU_READY && xtal_s2_q);
    end
  end

  // ---------------------------------------------------------------
  // crystal enable and pin control
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      o_XTAL_EN <= 1'b1;
    end else begin
      o_XTAL_EN <= !i_SLEEP || keep_crystal_running_q;
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      o_PIN_CMD <= 3'h0;
    end else begin
      o_PIN_CMD <= pin_ctrl_en_q ? pin_s2_q : 3'h0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_cal_never_auto: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    synth_cal_policy_q == CAL_NEVER && !i_MANUAL_CAL |=> !o_CAL_START)
    else $error("calibration started with policy never");
  a_cal_on_exit: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    synth_cal_policy_q == CAL_ON_EXIT && i_LEAVE_IDLE |=> o_CAL_START)
    else $error("no calibration on exit from idle");
  a_cal_on_idle: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    synth_cal_policy_q == CAL_ON_IDLE && i_BACK_TO_IDLE |=> o_CAL_START)
    else $error("no calibration on return to idle");
  a_cal_fourth_only: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    synth_cal_policy_q == CAL_EVERY_4 && !i_MANUAL_CAL
      |=> o_CAL_START == $past(i_BACK_TO_IDLE && idle_count_q == 2'h3))
    else $error("policy three calibrated on the wrong return");
  // the ready flop is fed by the state and crystal of the cycle before
  a_ready_needs_wait: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    $fell(o_CHIP_READY_N) |-> $past(pu_q == PU_READY && xtal_s2_q))
    else $error("chip ready before the wait ended");
  a_ready_lost: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    !xtal_s2_q |=> ##1 o_CHIP_READY_N)
    else $error("chip ready held without a stable crystal");
  a_upper_zero: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    i_ADDR == ADDR_CFG_A |=> o_RDATA[7:6] == 2'b00)
    else $error("upper configuration bits read nonzero");
  a_keep_crystal: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    i_SLEEP && keep_crystal_running_q |=> o_XTAL_EN)
    else $error("crystal stopped in sleep while kept");
  a_pin_ignored: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    !pin_ctrl_en_q |=> o_PIN_CMD == 3'h0)
    else $error("pin command passed while disabled");

  c_fourth_cal: cover property (@(posedge I_CLK) disable iff (!rst_n)
    synth_cal_policy_q == CAL_EVERY_4 && i_BACK_TO_IDLE
      && idle_count_q == 2'h3);
  c_chip_ready: cover property (@(posedge I_CLK) disable iff (!rst_n)
    $fell(o_CHIP_READY_N));
  c_sleep_off: cover property (@(posedge I_CLK) disable iff (!rst_n)
    $fell(o_XTAL_EN));

endmodule

// file: tb_top.sv
/*
  Self-checking bench for rspc_top: register access, calibration
  policies, power-on wait, crystal keep-alive and pin gating.
  Assumes the design files are compiled first; one 25 MHz clock.
*/
`timescale 1ns/10ps
module tb_top
  import rspc_pkg::*;
;
  localparam int RW = 2;
  localparam int P  = 4;
  logic       clk;
  logic       rst_n;
  logic       wr_en;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [2:0] evs;
  logic       sleep;
  logic       stable;
  logic [2:0] pins;
  logic       cal;
  logic       rdy_n;
  logic       xen;
  logic [2:0] pcmd;
  int         miscompares;
  int         tests_run;
  int         cal_cnt = 0;
  int         n;
  int         t;
  logic [7:0] rd;
  // --------------------------------------------------------------
  // clock, instance, pulse counter
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  rspc_top #(.RIPPLE_W(RW)) DUT (
    .I_CLK(clk), .I_RST_N(rst_n), .i_WR_EN(wr_en), .i_ADDR(addr),
    .i_WDATA(wdata), .o_RDATA(rdata), .i_MANUAL_CAL(evs[0]),
    .i_LEAVE_IDLE(evs[1]), .i_BACK_TO_IDLE(evs[2]), .i_SLEEP(sleep),
    .i_XTAL_STABLE(stable), .i_PIN_CTRL(pins), .o_CAL_START(cal),
    .o_CHIP_READY_N(rdy_n), .o_XTAL_EN(xen), .o_PIN_CMD(pcmd));
  // counted at the falling edge so a one-cycle pulse is never missed
  always @(negedge clk) begin
    if (cal === 1'b1) cal_cnt++;
  end
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen,
               exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    addr  = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  task automatic rdr(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    repeat (2) @(negedge clk);
    d = rdata;
  endtask
  // one event pulse, then the calibration pulses seen in 5 cycles
  task automatic ev(input int k, input int exp);
    int c0;
    c0 = cal_cnt;
    @(negedge clk);
    evs[k] = 1'b1;
    @(negedge clk);
    evs = 3'h0;
    repeat (5) @(negedge clk);
    chk(16'(cal_cnt - c0), 16'(exp));
  endtask
  task automatic cfg(input logic [1:0] pol, input logic [1:0] ws,
                     input logic pen, input logic keep);
    wr(ADDR_CFG_A, {2'h0, pol, ws, pen, keep});
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    results();
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    miscompares = 0;
    tests_run = 0;
    rst_n = 1'b0;
    wr_en = 1'b0;
    addr = 6'h00;
    wdata = 8'h00;
    evs = 3'h0;
    sleep = 1'b0;
    stable = 1'b0;
    pins = 3'h5;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    rdr(ADDR_CFG_A, rd);
    chk(rd, 16'h0004);
    rdr(ADDR_CFG_B, rd);
    chk(rd, 16'h0000);
    wr(ADDR_CFG_A, 8'hff);
    rdr(ADDR_CFG_A, rd);
    chk(rd, 16'h003f);
    wr(ADDR_CFG_B, 8'ha5);
    wr(6'h20, 8'h5a);
    rdr(ADDR_CFG_B, rd);
    chk(rd, 16'h00a5);
    rdr(6'h20, rd);
    chk(rd, 16'h0000);
    // pin gating and crystal keep-alive
    cfg(2'h0, 2'h1, 1'b0, 1'b0);
    sleep = 1'b1;
    repeat (5) @(negedge clk);
    chk(pcmd, 16'h0000);
    chk(xen, 16'h0000);
    cfg(2'h0, 2'h1, 1'b1, 1'b1);
    repeat (5) @(negedge clk);
    chk(pcmd, 16'h0005);
    chk(xen, 16'h0001);
    pins = 3'h2;
    repeat (5) @(negedge clk);
    chk(pcmd, 16'h0002);
    sleep = 1'b0;
    // calibration policies
    cfg(CAL_NEVER, 2'h1, 1'b0, 1'b0);
    ev(1, 0);
    ev(2, 0);
    ev(0, 1);
    cfg(CAL_ON_EXIT, 2'h1, 1'b0, 1'b0);
    ev(1, 1);
    ev(2, 0);
    ev(0, 1);
    cfg(CAL_ON_IDLE, 2'h1, 1'b0, 1'b0);
    ev(2, 1);
    ev(1, 0);
    ev(2, 1);
    cfg(CAL_EVERY_4, 2'h1, 1'b0, 1'b0);
    for (int r = 1; r <= 8; r++) begin
      ev(2, (r % 4 == 0) ? 1 : 0);
    end
    ev(1, 0);
    // power-on wait for every select value
    for (int s = 0; s < 4; s++) begin
      stable = 1'b0;
      // select two is the host's choice for a running crystal, zero for a
      // cold start
      cfg(2'h0, 2'(s), 1'b0, 1'b0);
      repeat (8) @(negedge clk);
      chk(rdy_n, 16'h0001);
      stable = 1'b1;
      n = 0;
      while (rdy_n !== 1'b0 && n < 1200) begin
        @(negedge clk);
        n++;
      end
      t = (s == 0) ? 1 : (s == 1) ? 16 : (s == 2) ? 64 : 256;
      chk(16'(n >= (t - 1) * P), 16'h1);
      chk(16'(n <= t * P + 8), 16'h1);
    end
    results();
  end
endmodule
